// File: bench/sewp_asserts.sv
// pin-level assertions for the protected serial memory
`timescale 1ns/10ps
module sewp_asserts #(
   parameter int unsigned WRITE_CYCLES = 40
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // watched pins
   input wire logic chip_select,
   input wire logic serial_clock,
   input wire logic serial_out,
   input wire logic serial_out_oe_n
);
   logic [3:0]  sclk_q;
   logic [3:0]  lo_q;
   logic [15:0] fall_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // cycles since the last serial clock rise
   always_ff @(posedge clk) begin
      if (!rst_n) sclk_q <= 4'hf;
      else if ($rose(serial_clock)) sclk_q <= 4'h0;
      else if (sclk_q != 4'hf) sclk_q <= sclk_q + 4'h1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n || chip_select) lo_q <= 4'h0;
      else if (lo_q != 4'hf) lo_q <= lo_q + 4'h1;
   end

   // cycles since select last fell, the start of any programming
   always_ff @(posedge clk) begin
      if (!rst_n) fall_q <= 16'hffff;
      else if ($fell(chip_select)) fall_q <= 16'h0;
      else if (fall_q != 16'hffff) fall_q <= fall_q + 16'h1;
   end

   property p_rst_quiet;
      $rose(rst_n) |-> serial_out_oe_n && !serial_out;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs not quiet after reset");

   property p_release;
      lo_q >= 4'h8 |-> serial_out_oe_n;
   endproperty
   a_release: assert property (p_release)
      else $error("output driven with select long low");

   property p_release_fast;
      $fell(chip_select) |-> ##[1:8] serial_out_oe_n;
   endproperty
   a_release_fast: assert property (p_release_fast)
      else $error("output not released after select fell");

   property p_drive_cause;
      $fell(serial_out_oe_n) |-> chip_select && (!$past(chip_select, 12) || sclk_q <= 4'h8);
   endproperty
   a_drive_cause: assert property (p_drive_cause)
      else $error("output driven without select or clock cause");

   property p_dummy_first;
      $fell(serial_out_oe_n) && sclk_q <= 4'h8 |-> !serial_out;
   endproperty
   a_dummy_first: assert property (p_dummy_first)
      else $error("read did not open with a zero bit");

   property p_data_step;
      !serial_out_oe_n && !$past(serial_out_oe_n) && $fell(serial_out) |-> sclk_q <= 4'h8;
   endproperty
   a_data_step: assert property (p_data_step)
      else $error("output fell without a clock rise");

   sequence s_ready;
      !serial_out_oe_n && !$past(serial_out_oe_n) && $rose(serial_out) && sclk_q > 4'h8;
   endsequence

   property p_ready_holds;
      s_ready |=> (serial_out || serial_out_oe_n || sclk_q <= 4'h8) [*4];
   endproperty
   a_ready_holds: assert property (p_ready_holds)
      else $error("ready indication dropped");

   property p_busy_time;
      s_ready |-> fall_q >= WRITE_CYCLES;
   endproperty
   a_busy_time: assert property (p_busy_time)
      else $error("ready shown before programming time");

   c_read: cover property ($fell(serial_out_oe_n) && sclk_q <= 4'h8);
   c_ready: cover property (s_ready);
   c_drop: cover property ($fell(chip_select) && !serial_out_oe_n);
endmodule

bind sewp_top sewp_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) i_sewp_asserts (.clk(clk), .rst_n(rst_n),
   .chip_select(chip_select), .serial_clock(serial_clock), .serial_out(serial_out),
   .serial_out_oe_n(serial_out_oe_n));

// File: bench/sewp_host.sv
// host model: serial master driving the memory pins
`timescale 1ns/10ps
module sewp_host (
   // clock
   input  wire logic clk,
   // pins to memory
   output logic      chip_select,
   output logic      serial_clock,
   output logic      serial_in,
   output logic      program_enable_pin,
   output logic      protect_unlock_pin,
   // pins from memory
   input  wire logic serial_out,
   input  wire logic serial_out_oe_n
);
   logic last_q;

   initial begin
      chip_select = 1'b0;
      serial_clock = 1'b0;
      serial_in = 1'b0;
      program_enable_pin = 1'b0;
      protect_unlock_pin = 1'b0;
      last_q = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic bit_x(input logic b, output logic q);
      serial_in <= b;
      tick(20);
      serial_clock <= 1'b1;
      tick(19);
      #1;
      q = (serial_out_oe_n !== 1'b0) ? ~last_q : serial_out;
      last_q = q;
      tick(1);
      serial_clock <= 1'b0;
   endtask

   task automatic frame(input logic pre, input logic pgm, input logic [10:0] h, output logic q);
      chip_select <= 1'b1;
      program_enable_pin <= pgm;
      protect_unlock_pin <= pre;
      tick(10);
      for (int i = 10; i >= 0; i--) bit_x(h[i], q);
   endtask

   task automatic word(input logic [15:0] d, output logic [15:0] q);
      for (int i = 15; i >= 0; i--) bit_x(d[i], q[i]);
   endtask

   task automatic close();
      tick(10);
      chip_select <= 1'b0;
      tick(20);
   endtask

   task automatic status(output logic busy, output logic ready);
      busy = 1'b0;
      ready = 1'b0;
      chip_select <= 1'b1;
      for (int i = 0; i < 400; i++) begin
         tick(1);
         #1;
         if (serial_out_oe_n === 1'b0 && serial_out === 1'b0) busy = 1'b1;
         if (serial_out_oe_n === 1'b0 && serial_out === 1'b1) ready = 1'b1;
         if (ready || (i == 20 && !busy)) break;
      end
      close();
   endtask
endmodule

// File: bench/tb_serial_eeprom_write_protect.sv
// self-checking bench for the protected serial memory
`timescale 1ns/10ps
module tb_serial_eeprom_write_protect;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cs, sclk, sin, pgm, pre, so, so_oe_n;
   logic [15:0] q16;
   logic        q1, busy, rdy;
   int          err_count = 0;
   int          n_checks = 0;
   int          cyc = 0;

   always #12.5 clk = ~clk;

   sewp_top #(.WRITE_CYCLES(40), .BIG_VARIANT(1'b1)) i_sewp_top (.clk(clk), .rst_n(rst_n), .chip_select(cs),
      .serial_clock(sclk), .serial_in(sin), .program_enable_pin(pgm), .protect_unlock_pin(pre),
      .serial_out(so), .serial_out_oe_n(so_oe_n));
   sewp_host i_sewp_host (.clk(clk), .chip_select(cs), .serial_clock(sclk), .serial_in(sin),
      .program_enable_pin(pgm), .protect_unlock_pin(pre), .serial_out(so), .serial_out_oe_n(so_oe_n));

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         results();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic p, input logic e, input logic [7:0] a);
      i_sewp_host.frame(p, e, {3'b100, a}, q1);
      i_sewp_host.close();
   endtask

   // programming instruction, acceptance judged by busy then ready status
   task automatic prog(input logic p, input logic e, input logic [1:0] op, input logic [7:0] a,
                       input logic [15:0] d, input bit wd, input bit ok);
      i_sewp_host.frame(p, e, {1'b1, op, a}, q1);
      if (wd) i_sewp_host.word(d, q16);
      i_sewp_host.close();
      i_sewp_host.status(busy, rdy);
      chk({14'h0, busy, rdy}, ok ? 16'h3 : 16'h0);
   endtask

   task automatic rd(input logic p, input logic [7:0] a, input logic [15:0] exp);
      i_sewp_host.frame(p, 1'b0, {3'b110, a}, q1);
      chk({15'h0, q1}, 16'h0);
      i_sewp_host.word(16'h0, q16);
      chk(q16, exp);
   endtask

   task automatic t_basic();
      rd(1'b0, 8'h80, 16'hffff);
      i_sewp_host.close();
      chk({15'h0, so_oe_n}, 16'h1);
      prog(1'b0, 1'b1, sewp_pkg::OPC_WRITE, 8'h03, 16'h1234, 1, 0);
      cmd(1'b0, 1'b1, 8'hc0);
      prog(1'b0, 1'b0, sewp_pkg::OPC_WRITE, 8'h03, 16'h1234, 1, 0);
      prog(1'b0, 1'b1, sewp_pkg::OPC_WRITE, 8'hff, 16'ha5c3, 1, 1);
      prog(1'b0, 1'b1, sewp_pkg::OPC_WRITE, 8'h00, 16'h1234, 1, 1);
      $display("test basic done");
   endtask

   task automatic t_stream();
      rd(1'b0, 8'hff, 16'ha5c3);
      i_sewp_host.word(16'h0, q16);
      chk(q16, 16'h1234);
      i_sewp_host.word(16'h0, q16);
      chk(q16, 16'hffff);
      i_sewp_host.close();
      $display("test stream done");
   endtask

   task automatic t_protect();
      cmd(1'b1, 1'b1, 8'hc0);
      prog(1'b1, 1'b1, sewp_pkg::OPC_PCLR, 8'hff, 16'h0, 0, 1);
      prog(1'b0, 1'b1, sewp_pkg::OPC_MISC, 8'h40, 16'h0f0f, 1, 1);
      rd(1'b0, 8'h7f, 16'h0f0f);
      i_sewp_host.close();
      cmd(1'b1, 1'b1, 8'hc0);
      prog(1'b1, 1'b1, sewp_pkg::OPC_WRITE, 8'h10, 16'h0, 0, 1);
      rd(1'b1, 8'h00, 16'h1000);
      i_sewp_host.close();
      prog(1'b0, 1'b1, sewp_pkg::OPC_WRITE, 8'h10, 16'hbeef, 1, 0);
      prog(1'b0, 1'b1, sewp_pkg::OPC_WRITE, 8'h0f, 16'hbeef, 1, 1);
      prog(1'b0, 1'b1, sewp_pkg::OPC_MISC, 8'h40, 16'h0, 1, 0);
      rd(1'b0, 8'h0f, 16'hbeef);
      i_sewp_host.word(16'h0, q16);
      chk(q16, 16'h0f0f);
      i_sewp_host.close();
      cmd(1'b1, 1'b1, 8'hc0);
      rd(1'b0, 8'h00, 16'h0f0f);
      i_sewp_host.close();
      prog(1'b1, 1'b1, sewp_pkg::OPC_PCLR, 8'hff, 16'h0, 0, 0);
      cmd(1'b1, 1'b1, 8'hc0);
      prog(1'b1, 1'b1, sewp_pkg::OPC_MISC, 8'h00, 16'h0, 0, 1);
      cmd(1'b1, 1'b1, 8'hc0);
      prog(1'b1, 1'b1, sewp_pkg::OPC_PCLR, 8'hff, 16'h0, 0, 0);
      rd(1'b1, 8'h00, 16'h1000);
      i_sewp_host.close();
      cmd(1'b0, 1'b0, 8'h00);
      prog(1'b0, 1'b1, sewp_pkg::OPC_WRITE, 8'h01, 16'h0, 1, 0);
      $display("test protect done");
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_basic();
      t_stream();
      t_protect();
      results();
   end
endmodule

// File: logic/sewp_pkg.sv
// constants, carriers and enumerations for the protected serial nonvolatile memory
package sewp_pkg;

   // clock and programming time
   localparam int unsigned CLK_KHZ   = 40000;
   localparam int unsigned T_WP_MS   = 10;
   localparam int unsigned WP_CYCLES = T_WP_MS * CLK_KHZ;
   localparam int unsigned PCNT_W    = 20;
   typedef logic [PCNT_W-1:0] sewp_pcnt_t;

   // array geometry
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned WORDS_BIG  = 256;
   localparam int unsigned WORDS_SMALL = 128;
   localparam logic [7:0]  ADDR_MASK_BIG   = 8'hff;
   localparam logic [7:0]  ADDR_MASK_SMALL = 8'h7f;

   // serial frame counts
   localparam logic [3:0] HDR_LAST_BIT  = 4'h9;
   localparam logic [3:0] DATA_LAST_BIT = 4'hf;
   localparam logic [4:0] RD_WORD_BITS  = 5'h10;
   localparam logic [4:0] RD_PROT_BITS  = 5'h08;

   // opcodes and sub-codes carried in the top address bits
   localparam logic [1:0] OPC_READ  = 2'h2;
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_MISC  = 2'h0;
   localparam logic [1:0] OPC_PCLR  = 2'h3;
   localparam logic [1:0] SUB_UNLOCK = 2'h3;
   localparam logic [1:0] SUB_FILL   = 2'h1;
   localparam logic [1:0] SUB_LOCK   = 2'h0;
   localparam logic [7:0] PROT_CLEAR_ADDR  = 8'hff;
   localparam logic [7:0] PROT_FREEZE_ADDR = 8'h00;

   // values after reset
   localparam logic [7:0]  PROT_RST = 8'hff;
   localparam logic [15:0] MEM_RST  = 16'hffff;

   // synchronised pin group
   typedef struct packed {
      logic cs;
      logic sclk;
      logic sin;
      logic pgm;
      logic pre;
   } sewp_pins_s;

   typedef enum {
      ST_IDLE,
      ST_HDR,
      ST_DATA,
      ST_READ,
      ST_DONE
   } sewp_state_e;

   typedef enum {
      OP_NONE,
      OP_WRITE,
      OP_FILL,
      OP_PCLR,
      OP_PSET,
      OP_PFRZ
   } sewp_op_e;

endpackage

// File: logic/sewp_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module sewp_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // pin in
   input  wire logic raw,
   // filtered level and edges
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;
   logic agree;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         s3_q  <= 1'b0;
         lvl_q <= 1'b0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (agree) begin
            lvl_q <= s3_q;
         end
      end
   end

   assign agree = (s2_q == s3_q);
   assign level = lvl_q;
   assign rise  = agree & s3_q & ~lvl_q;
   assign fall  = agree & ~s3_q & lvl_q;

endmodule

// File: logic/sewp_top.sv
// protected serial nonvolatile memory: command decode, array, protect register and timed programming
//
// Function
// R1: array of 128 or 256 16-bit words
// R2: protect register holds first protected address
// R3: writes at or above protect value abandoned
// R4: protect value can be frozen forever; here frozen_q clears again at reset
// R5: read loads start address into pointer
// R6: read streams words, pointer auto-advances
// R7: host may stop read after any word
// R8: self-timed programming, no erase needed
// R9: writes need program enable pin high
// R10: unprotected write programs one whole word
// R11: select high after start shows ready/busy
// R12: host keeps select low between instructions
// R13: host keeps serial clock period long enough
// R14: output released while select low
// R15: start bit, two opcode bits, eight address
// R16: one dummy zero before first read word
// R17: programming locked after reset until unlocked
// R18: protect unlock immediately precedes protect ops
// R19: busy ignores new instructions, shows busy low
// R20: read pointer wraps at end of array
`timescale 1ns/10ps
module sewp_top #(
   parameter int unsigned WRITE_CYCLES = sewp_pkg::WP_CYCLES,
   parameter bit          BIG_VARIANT  = 1'b1
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // serial pins from host
   input  wire logic chip_select,
   input  wire logic serial_clock,
   input  wire logic serial_in,
   input  wire logic program_enable_pin,
   input  wire logic protect_unlock_pin,
   // serial output pin
   output logic      serial_out,
   output logic      serial_out_oe_n
);

   sewp_pkg::sewp_pins_s  pins_raw;
   sewp_pkg::sewp_pins_s  pins_lvl;
   sewp_pkg::sewp_pins_s  pins_rise;
   sewp_pkg::sewp_pins_s  pins_fall;

   sewp_pkg::sewp_state_e state_q;
   sewp_pkg::sewp_op_e    pend_op_q;
   sewp_pkg::sewp_op_e    prog_op_q;
   sewp_pkg::sewp_op_e    hdr_op;

   logic [sewp_pkg::WORD_W-1:0] mem_q [sewp_pkg::WORDS_BIG];
   logic [9:0]                  hdr_q;
   logic [9:0]                  hdr_next;
   logic [3:0]                  cnt_q;
   logic [15:0]                 dat_q;
   logic [15:0]                 dat_next;
   logic [7:0]                  pend_adr_q;
   logic [15:0]                 prog_dat_q;
   logic [7:0]                  prog_adr_q;
   logic                        pend_ready_q;
   sewp_pkg::sewp_pcnt_t        pcnt_q;
   logic                        busy_q;
   logic                        status_q;
   logic                        wen_q;
   logic                        armed_q;
   logic [7:0]                  prot_q;
   logic                        prot_valid_q;
   logic                        frozen_q;
   logic [7:0]                  ptr_q;
   logic [7:0]                  ptr_next;
   logic [15:0]                 rd_sh_q;
   logic [4:0]                  rd_cnt_q;
   logic                        rd_on_q;
   logic                        rd_prot_q;
   logic                        out_q;
   logic                        oe_n_q;

   logic       sclk_edge;
   logic       start_bit;
   logic       hdr_last;
   logic       data_last;
   logic       prog_start;
   logic       prog_done;
   logic [1:0] opc;
   logic [7:0] adr_raw;
   logic [7:0] adr;
   logic [7:0] adr_mask;
   logic       cmd_read;
   logic       cmd_pread;
   logic       cmd_wen;
   logic       cmd_wlock;
   logic       cmd_punlock;
   logic       has_data;

   assign pins_raw = '{chip_select, serial_clock, serial_in, program_enable_pin, protect_unlock_pin};

   // every pin passes its own filtered synchroniser
   for (genvar i = 0; i < $bits(sewp_pkg::sewp_pins_s); i++) begin : g_sync
      sewp_sync u_sync (
         .clk   (clk),
         .rst_n (rst_n),
         .raw   (pins_raw[i]),
         .level (pins_lvl[i]),
         .rise  (pins_rise[i]),
         .fall  (pins_fall[i])
      );
   end

   assign sclk_edge = pins_lvl.cs & pins_rise.sclk;
   assign adr_mask  = BIG_VARIANT ? sewp_pkg::ADDR_MASK_BIG : sewp_pkg::ADDR_MASK_SMALL;
   // R19: no start while busy
   assign start_bit = sclk_edge & (state_q == sewp_pkg::ST_IDLE) & pins_lvl.sin & ~busy_q;
   // R15: ten header bits
   assign hdr_next  = {hdr_q[8:0], pins_lvl.sin};
   assign hdr_last  = sclk_edge & (state_q == sewp_pkg::ST_HDR) & (cnt_q == sewp_pkg::HDR_LAST_BIT);
   assign dat_next  = {dat_q[14:0], pins_lvl.sin};
   assign data_last = sclk_edge & (state_q == sewp_pkg::ST_DATA) & (cnt_q == sewp_pkg::DATA_LAST_BIT);
   assign opc       = hdr_next[9:8];
   assign adr_raw   = hdr_next[7:0];
   assign adr       = adr_raw & adr_mask;

   // R15: instruction decode
   assign cmd_read  = ~pins_lvl.pre & (opc == sewp_pkg::OPC_READ);
   assign cmd_pread = pins_lvl.pre & (opc == sewp_pkg::OPC_READ);
   // R17: unlock and lock of programming
   assign cmd_wen   = ~pins_lvl.pre & (opc == sewp_pkg::OPC_MISC) & (adr_raw[7:6] == sewp_pkg::SUB_UNLOCK)
                      & pins_lvl.pgm;
   assign cmd_wlock = ~pins_lvl.pre & (opc == sewp_pkg::OPC_MISC) & (adr_raw[7:6] == sewp_pkg::SUB_LOCK);
   // R18: protect unlock needs both pins and programming enabled
   assign cmd_punlock = pins_lvl.pre & (opc == sewp_pkg::OPC_MISC) & (adr_raw[7:6] == sewp_pkg::SUB_UNLOCK)
                        & pins_lvl.pgm & wen_q;
   assign has_data  = ~pins_lvl.pre & ((opc == sewp_pkg::OPC_WRITE)
                      | ((opc == sewp_pkg::OPC_MISC) & (adr_raw[7:6] == sewp_pkg::SUB_FILL)));

   // operation that an instruction would program, or none if refused
   always_comb begin
      hdr_op = sewp_pkg::OP_NONE;
      if (!pins_lvl.pre) begin
         // R9: program enable pin must be high
         if (pins_lvl.pgm && wen_q) begin
            // R3: protected addresses are abandoned
            if (opc == sewp_pkg::OPC_WRITE && (!prot_valid_q || adr < prot_q)) begin
               hdr_op = sewp_pkg::OP_WRITE;
            end else if (opc == sewp_pkg::OPC_MISC && adr_raw[7:6] == sewp_pkg::SUB_FILL && !prot_valid_q) begin
               hdr_op = sewp_pkg::OP_FILL;
            end
         end
      end else if (pins_lvl.pgm && armed_q && !frozen_q) begin
         // R4: frozen protect register refuses all changes
         if (opc == sewp_pkg::OPC_PCLR && adr_raw == sewp_pkg::PROT_CLEAR_ADDR) begin
            hdr_op = sewp_pkg::OP_PCLR;
         end else if (opc == sewp_pkg::OPC_WRITE && !prot_valid_q) begin
            hdr_op = sewp_pkg::OP_PSET;
         end else if (opc == sewp_pkg::OPC_MISC && adr_raw == sewp_pkg::PROT_FREEZE_ADDR) begin
            hdr_op = sewp_pkg::OP_PFRZ;
         end
      end
   end

   // frame sequencing on serial clock rising edges
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= sewp_pkg::ST_IDLE;
         cnt_q   <= 4'h0;
         hdr_q   <= 10'h000;
         dat_q   <= 16'h0000;
      end else if (!pins_lvl.cs) begin
         state_q <= sewp_pkg::ST_IDLE;
         cnt_q   <= 4'h0;
      end else if (sclk_edge) begin
         case (state_q)
            sewp_pkg::ST_IDLE: begin
               if (start_bit) begin
                  state_q <= sewp_pkg::ST_HDR;
                  cnt_q   <= 4'h0;
               end
            end
            sewp_pkg::ST_HDR: begin
               hdr_q <= hdr_next;
               cnt_q <= cnt_q + 4'h1;
               if (hdr_last) begin
                  cnt_q <= 4'h0;
                  if (cmd_read || cmd_pread) begin
                     state_q <= sewp_pkg::ST_READ;
                  end else if (has_data) begin
                     state_q <= sewp_pkg::ST_DATA;
                  end else begin
                     state_q <= sewp_pkg::ST_DONE;
                  end
               end
            end
            sewp_pkg::ST_DATA: begin
               dat_q <= dat_next;
               cnt_q <= cnt_q + 4'h1;
               if (data_last) begin
                  state_q <= sewp_pkg::ST_DONE;
               end
            end
            sewp_pkg::ST_READ: begin
               state_q <= sewp_pkg::ST_READ;
            end
            sewp_pkg::ST_DONE: begin
               state_q <= sewp_pkg::ST_DONE;
            end
            default: begin
               state_q <= sewp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // pending operation waits for the select fall
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pend_op_q    <= sewp_pkg::OP_NONE;
         pend_adr_q   <= 8'h00;
         pend_ready_q <= 1'b0;
      end else if (!pins_lvl.cs) begin
         pend_ready_q <= 1'b0;
      end else if (hdr_last) begin
         pend_op_q    <= hdr_op;
         pend_adr_q   <= adr;
         pend_ready_q <= ~has_data & (hdr_op != sewp_pkg::OP_NONE);
      end else if (data_last) begin
         pend_ready_q <= (pend_op_q != sewp_pkg::OP_NONE);
      end
   end

   // programming enable and protect arming
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // R17: locked after reset
         wen_q   <= 1'b0;
         armed_q <= 1'b0;
      end else if (hdr_last) begin
         if (cmd_wen) begin
            wen_q <= 1'b1;
         end else if (cmd_wlock) begin
            wen_q <= 1'b0;
         end
         // R18: any other instruction disarms
         armed_q <= cmd_punlock;
      end
   end

   // R8: self-timed programming cycle
   assign prog_start = pins_fall.cs & pend_ready_q & ~busy_q;
   assign prog_done  = busy_q & (pcnt_q == '0);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy_q     <= 1'b0;
         pcnt_q     <= '0;
         prog_op_q  <= sewp_pkg::OP_NONE;
         prog_adr_q <= 8'h00;
         prog_dat_q <= 16'h0000;
      end else if (prog_start) begin
         busy_q     <= 1'b1;
         pcnt_q     <= sewp_pkg::sewp_pcnt_t'(WRITE_CYCLES - 1);
         prog_op_q  <= pend_op_q;
         prog_adr_q <= pend_adr_q;
         prog_dat_q <= dat_q;
      end else if (prog_done) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         pcnt_q <= pcnt_q - sewp_pkg::sewp_pcnt_t'(1);
      end
   end

   // R11: status shown from programming start until next start bit
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_q <= 1'b0;
      end else if (prog_start) begin
         status_q <= 1'b1;
      end else if (start_bit) begin
         status_q <= 1'b0;
      end
   end

   // R1: word array, R10: whole word per write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < sewp_pkg::WORDS_BIG; i++) begin
            mem_q[i] <= sewp_pkg::MEM_RST;
         end
      end else if (prog_done) begin
         if (prog_op_q == sewp_pkg::OP_WRITE) begin
            mem_q[prog_adr_q] <= prog_dat_q;
         end else if (prog_op_q == sewp_pkg::OP_FILL) begin
            for (int i = 0; i < sewp_pkg::WORDS_BIG; i++) begin
               mem_q[i] <= prog_dat_q;
            end
         end
      end
   end

   // R2: protect register, R4: freeze
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prot_q       <= sewp_pkg::PROT_RST;
         prot_valid_q <= 1'b0;
         frozen_q     <= 1'b0;
      end else if (prog_done) begin
         case (prog_op_q)
            sewp_pkg::OP_PCLR: begin
               prot_q       <= sewp_pkg::PROT_RST;
               prot_valid_q <= 1'b0;
            end
            sewp_pkg::OP_PSET: begin
               prot_q       <= prog_adr_q;
               prot_valid_q <= 1'b1;
            end
            sewp_pkg::OP_PFRZ: begin
               frozen_q <= 1'b1;
            end
            default: begin
               frozen_q <= frozen_q;
            end
         endcase
      end
   end

   // R20: pointer wraps inside the array size
   assign ptr_next = (ptr_q + 8'h01) & adr_mask;

   // read shifter and output bit
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptr_q     <= 8'h00;
         rd_sh_q   <= 16'h0000;
         rd_cnt_q  <= 5'h00;
         rd_on_q   <= 1'b0;
         rd_prot_q <= 1'b0;
         out_q     <= 1'b0;
      end else if (!pins_lvl.cs) begin
         rd_on_q <= 1'b0;
      end else if (hdr_last && (cmd_read || cmd_pread)) begin
         // R5: load pointer, R16: dummy zero first
         ptr_q     <= adr;
         rd_sh_q   <= cmd_read ? mem_q[adr] : {prot_q, 8'h00};
         rd_cnt_q  <= cmd_read ? sewp_pkg::RD_WORD_BITS : sewp_pkg::RD_PROT_BITS;
         rd_prot_q <= cmd_pread;
         rd_on_q   <= 1'b1;
         out_q     <= 1'b0;
      end else if (sclk_edge && rd_on_q) begin
         // R6: continuous stream without repeated dummy
         out_q <= rd_sh_q[15];
         if (rd_cnt_q == 5'h01) begin
            rd_cnt_q <= sewp_pkg::RD_WORD_BITS;
            if (rd_prot_q) begin
               rd_sh_q <= 16'h0000;
            end else begin
               ptr_q   <= ptr_next;
               rd_sh_q <= mem_q[ptr_next];
            end
         end else begin
            rd_sh_q  <= {rd_sh_q[14:0], 1'b0};
            rd_cnt_q <= rd_cnt_q - 5'h01;
         end
      end else if (status_q && state_q == sewp_pkg::ST_IDLE) begin
         // R19: busy reads low, ready high
         out_q <= ~busy_q;
      end
   end

   // R14: released whenever select is low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= ~(pins_lvl.cs & (rd_on_q | (status_q & (state_q == sewp_pkg::ST_IDLE))));
      end
   end

   assign serial_out      = out_q;
   assign serial_out_oe_n = oe_n_q;

endmodule
